//--- hw/rpac_top.v
`timescale 1ns/1ns
`include "rpac_defs.vh"

module rpac_top (
   input  wire        clock,
   input  wire        rst_b,
   input  wire        mpu_enable,
   input  wire        privileged_background_enable,
   input  wire        hfnmi_enable,
   input  wire        handler_escalated,
   input  wire        prog_we,
   input  wire [1:0]  prog_word,
   input  wire [31:0] prog_wdata,
   input  wire [1:0]  prog_rword,
   output reg  [31:0] prog_rdata,
   output reg  [7:0]  region_select_reg,
   input  wire        acc_valid,
   input  wire [31:0] acc_addr,
   input  wire        acc_write,
   input  wire        acc_priv,
   input  wire        acc_fetch,
   output wire        acc_fault,
   output reg         attr_valid,
   output reg         attr_region_hit,
   output reg  [2:0]  attr_region,
   output reg  [1:0]  attr_mem_type,
   output reg         attr_shareable,
   output reg  [1:0]  attr_inner_cache_policy,
   output reg  [1:0]  attr_outer_cache_policy,
   output reg         attr_impl_defined,
   output reg         memfault_exc,
   input  wire [7:0]  memfault_clear,
   output reg  [7:0]  memfault_status_bits,
   output reg  [31:0] fault_addr
);

   // permission table for one access
   function perm_allows;
      input [2:0] perm;
      input       priv;
      input       wr;
      begin
         case (perm)
            `RPAC_PERM_NONE:    perm_allows = 1'b0;
            `RPAC_PERM_PRIV_RW: perm_allows = priv;
            `RPAC_PERM_USER_RO: perm_allows = priv | ~wr;
            `RPAC_PERM_FULL:    perm_allows = 1'b1;
            `RPAC_PERM_RSVD:    perm_allows = 1'b0;
            `RPAC_PERM_PRIV_RO: perm_allows = priv & ~wr;
            `RPAC_PERM_RO_A:    perm_allows = ~wr;
            `RPAC_PERM_RO_B:    perm_allows = ~wr;
            default:            perm_allows = 1'b0;
         endcase
      end
   endfunction

   // one programming word selected
   function word_hit;
      input       we;
      input [1:0] word;
      input [1:0] target;
      begin
         word_hit = we && (word == target);
      end
   endfunction

   // reset synchroniser
   reg rst_meta_ff;
   reg rst_sync_ff;

   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   wire rst_sync_b = rst_sync_ff;

   // region storage
   reg [26:0] base_ff [0:`RPAC_REGION_COUNT-1];
   reg [31:0] attr_ff [0:`RPAC_REGION_COUNT-1];
   reg [7:0]  select_ff;

   wire       wr_select = word_hit(prog_we, prog_word, `RPAC_WORD_SELECT);
   wire       wr_base   = word_hit(prog_we, prog_word, `RPAC_WORD_BASE);
   wire       wr_attr   = word_hit(prog_we, prog_word, `RPAC_WORD_ATTR);
   wire       base_sel  = prog_wdata[`RPAC_BASE_VALID];
   wire [2:0] base_idx  = base_sel ?
                          prog_wdata[`RPAC_REGION_IDX_W-1:0] :
                          select_ff[`RPAC_REGION_IDX_W-1:0];

   reg [7:0] nxt_select;

   always @* begin
      nxt_select = select_ff;
      if (wr_select)
         nxt_select = prog_wdata[7:0];
      else if (wr_base && base_sel)
         nxt_select = {4'h0,
            prog_wdata[`RPAC_BASE_REGION_HI:`RPAC_BASE_REGION_LO]};
   end

   integer ri;

   always @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         select_ff <= `RPAC_RESET_SELECT;
         for (ri = 0; ri < `RPAC_REGION_COUNT; ri = ri + 1) begin
            base_ff[ri] <= `RPAC_RESET_BASE;
            attr_ff[ri] <= `RPAC_RESET_WORD;
         end
      end else begin
         select_ff <= nxt_select;
         if (wr_base)
            base_ff[base_idx] <= prog_wdata[31:`RPAC_BASE_ADDR_LO];
         if (wr_attr)
            attr_ff[select_ff[`RPAC_REGION_IDX_W-1:0]] <= prog_wdata;
      end
   end

   // register readback
   reg [31:0] nxt_rdata;

   always @* begin
      case (prog_rword)
         `RPAC_WORD_SELECT: nxt_rdata = {24'h00_0000, select_ff};
         `RPAC_WORD_BASE:   nxt_rdata =
            {base_ff[select_ff[`RPAC_REGION_IDX_W-1:0]], 1'b0,
             select_ff[3:0]};
         `RPAC_WORD_ATTR:   nxt_rdata =
            attr_ff[select_ff[`RPAC_REGION_IDX_W-1:0]];
         default:           nxt_rdata = `RPAC_RESET_WORD;
      endcase
   end

   always @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         prog_rdata        <= `RPAC_RESET_WORD;
         region_select_reg <= `RPAC_RESET_SELECT;
      end else begin
         prog_rdata        <= nxt_rdata;
         region_select_reg <= nxt_select;
      end
   end

   // per-region match, same check for fetch and data
   wire [`RPAC_REGION_COUNT-1:0] hit;

   genvar gi;
   generate
      for (gi = 0; gi < `RPAC_REGION_COUNT; gi = gi + 1) begin : g_match
         rpac_region_match u_match (
            .addr   (acc_addr),
            .base   (base_ff[gi]),
            .size   (attr_ff[gi][`RPAC_ATTR_SIZE_HI:`RPAC_ATTR_SIZE_LO]),
            .enable (attr_ff[gi][`RPAC_ATTR_ENABLE]),
            .mask   (attr_ff[gi][`RPAC_ATTR_MASK_HI:`RPAC_ATTR_MASK_LO]),
            .hit    (hit[gi])
         );
      end
   endgenerate

   // highest numbered hit wins; disabled subregions already drop out
   integer    wi;
   reg        win_hit;
   reg [2:0]  win_idx;

   always @* begin
      win_hit = 1'b0;
      win_idx = 3'h0;
      for (wi = 0; wi < `RPAC_REGION_COUNT; wi = wi + 1) begin
         if (hit[wi]) begin
            win_hit = 1'b1;
            win_idx = wi[2:0];
         end
      end
   end

   wire [31:0] win_attr = attr_ff[win_idx];
   wire [2:0]  win_perm = win_attr[`RPAC_ATTR_PERM_HI:`RPAC_ATTR_PERM_LO];
   wire        win_nx   = win_attr[`RPAC_ATTR_NOEXEC];

   // protection off, or escalated handler without the override
   wire mpu_active = mpu_enable & ~(handler_escalated & ~hfnmi_enable);

   wire is_write   = acc_write & ~acc_fetch;
   wire perm_ok    = perm_allows(win_perm, acc_priv, is_write);
   wire nx_fault   = acc_fetch & win_nx;
   wire region_bad = ~perm_ok | nx_fault;
   // no region: background only for privileged software
   wire miss_bad   = ~(acc_priv & privileged_background_enable);

   assign acc_fault = acc_valid & mpu_active &
                      (win_hit ? region_bad : miss_bad);

   // memory attributes of the winning region
   wire [1:0] dec_type;
   wire       dec_share;
   wire [1:0] dec_inner;
   wire [1:0] dec_outer;
   wire       dec_impl;

   rpac_attr_decode u_decode (
      .type_ext           (win_attr[`RPAC_ATTR_EXT_HI:`RPAC_ATTR_EXT_LO]),
      .cache_bit          (win_attr[`RPAC_ATTR_C]),
      .buf_bit            (win_attr[`RPAC_ATTR_B]),
      .share_bit          (win_attr[`RPAC_ATTR_S]),
      .mem_type           (dec_type),
      .shareable          (dec_share),
      .inner_cache_policy (dec_inner),
      .outer_cache_policy (dec_outer),
      .impl_defined       (dec_impl)
   );

   always @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         attr_valid              <= 1'b0;
         attr_region_hit         <= 1'b0;
         attr_region             <= 3'h0;
         attr_mem_type           <= `RPAC_MT_STRONG;
         attr_shareable          <= 1'b0;
         attr_inner_cache_policy <= `RPAC_POL_NC;
         attr_outer_cache_policy <= `RPAC_POL_NC;
         attr_impl_defined       <= 1'b0;
      end else begin
         attr_valid <= acc_valid;
         if (acc_valid) begin
            attr_region_hit         <= win_hit & mpu_active;
            attr_region             <= win_idx;
            attr_mem_type           <= dec_type;
            attr_shareable          <= dec_share;
            attr_inner_cache_policy <= dec_inner;
            attr_outer_cache_policy <= dec_outer;
            attr_impl_defined       <= dec_impl;
         end
      end
   end

   // fault status, set wins over a same-cycle clear
   reg [7:0] set_bits;
   reg [7:0] nxt_status;

   always @* begin
      set_bits = 8'h00;
      if (acc_fault) begin
         if (acc_fetch) begin
            set_bits[`RPAC_MFS_FETCH_VIOL] = 1'b1;
         end else begin
            set_bits[`RPAC_MFS_DATA_VIOL]  = 1'b1;
            set_bits[`RPAC_MFS_ADDR_VALID] = 1'b1;
         end
      end
      nxt_status = (memfault_status_bits & ~memfault_clear) | set_bits;
   end

   always @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         memfault_exc         <= 1'b0;
         memfault_status_bits <= `RPAC_RESET_STATUS;
         fault_addr           <= `RPAC_RESET_WORD;
      end else begin
         memfault_exc         <= acc_fault;
         memfault_status_bits <= nxt_status;
         if (acc_fault && !acc_fetch)
            fault_addr <= acc_addr;
      end
   end

endmodule

//--- hw/rpac_defs.vh
`ifndef RPAC_DEFS_VH
`define RPAC_DEFS_VH

// region programming words, consecutive word indices
`define RPAC_WORD_SELECT      2'h0
`define RPAC_WORD_BASE        2'h1
`define RPAC_WORD_ATTR        2'h2

`define RPAC_REGION_COUNT     8
`define RPAC_REGION_IDX_W     3

// region_base_reg fields
`define RPAC_BASE_REGION_HI   3
`define RPAC_BASE_REGION_LO   0
`define RPAC_BASE_VALID       4
`define RPAC_BASE_ADDR_LO     5

// region_attr_size_reg fields
`define RPAC_ATTR_ENABLE      0
`define RPAC_ATTR_SIZE_HI     5
`define RPAC_ATTR_SIZE_LO     1
`define RPAC_ATTR_MASK_HI     15
`define RPAC_ATTR_MASK_LO     8
`define RPAC_ATTR_B           16
`define RPAC_ATTR_C           17
`define RPAC_ATTR_S           18
`define RPAC_ATTR_EXT_HI      21
`define RPAC_ATTR_EXT_LO      19
`define RPAC_ATTR_PERM_HI     26
`define RPAC_ATTR_PERM_LO     24
`define RPAC_ATTR_NOEXEC      28

// smallest size code that has subregions (256 bytes)
`define RPAC_SIZE_SUBREGION   5'h07

// reset values
`define RPAC_RESET_WORD       32'h0000_0000
`define RPAC_RESET_BASE       27'h000_0000
`define RPAC_RESET_SELECT     8'h00
`define RPAC_RESET_STATUS     8'h00

// memory types
`define RPAC_MT_STRONG        2'h0
`define RPAC_MT_DEVICE        2'h1
`define RPAC_MT_NORMAL        2'h2
`define RPAC_MT_RESERVED      2'h3

// cache policy codes
`define RPAC_POL_NC           2'h0
`define RPAC_POL_WB_WRA       2'h1
`define RPAC_POL_WT_NWA       2'h2
`define RPAC_POL_WB_NWA       2'h3

// access permission codes
`define RPAC_PERM_NONE        3'h0
`define RPAC_PERM_PRIV_RW     3'h1
`define RPAC_PERM_USER_RO     3'h2
`define RPAC_PERM_FULL        3'h3
`define RPAC_PERM_RSVD        3'h4
`define RPAC_PERM_PRIV_RO     3'h5
`define RPAC_PERM_RO_A        3'h6
`define RPAC_PERM_RO_B        3'h7

// memfault_status_bits positions
`define RPAC_MFS_FETCH_VIOL   0
`define RPAC_MFS_DATA_VIOL    1
`define RPAC_MFS_ADDR_VALID   7

`endif

//--- hw/rpac_region_match.v
`timescale 1ns/1ns
`include "rpac_defs.vh"

// address match of one region, with subregion disables applied
module rpac_region_match (
   input  wire [31:0] addr,
   input  wire [26:0] base,
   input  wire [4:0]  size,
   input  wire        enable,
   input  wire [7:0]  mask,
   output reg         hit
);

   integer    i;
   reg        in_range;
   reg [31:0] shifted;
   reg [2:0]  sub_idx;

   always @* begin
      in_range = 1'b1;
      // region spans 2^(size+1) bytes; compare the bits above that
      for (i = `RPAC_BASE_ADDR_LO; i < 32; i = i + 1) begin
         if (i > size && addr[i] != base[i - `RPAC_BASE_ADDR_LO])
            in_range = 1'b0;
      end
      shifted = addr >> (size - 5'h02);
      sub_idx = shifted[2:0];
      hit     = enable & in_range;
      // bit 0 of the mask is the lowest-addressed eighth
      if (size >= `RPAC_SIZE_SUBREGION && mask[sub_idx])
         hit = 1'b0;
   end

endmodule

//--- hw/rpac_attr_decode.v
`timescale 1ns/1ns
`include "rpac_defs.vh"

// memory type and cache policy decode of one region
module rpac_attr_decode (
   input  wire [2:0] type_ext,
   input  wire       cache_bit,
   input  wire       buf_bit,
   input  wire       share_bit,
   output reg  [1:0] mem_type,
   output reg        shareable,
   output reg  [1:0] inner_cache_policy,
   output reg  [1:0] outer_cache_policy,
   output reg        impl_defined
);

   always @* begin
      mem_type           = `RPAC_MT_RESERVED;
      shareable          = share_bit;
      inner_cache_policy = `RPAC_POL_NC;
      outer_cache_policy = `RPAC_POL_NC;
      impl_defined       = 1'b0;
      if (type_ext[2]) begin
         mem_type           = `RPAC_MT_NORMAL;
         outer_cache_policy = type_ext[1:0];
         inner_cache_policy = {cache_bit, buf_bit};
      end else begin
         case ({type_ext[1:0], cache_bit, buf_bit})
            4'h0: begin
               mem_type  = `RPAC_MT_STRONG;
               shareable = 1'b1;
            end
            4'h1: begin
               mem_type  = `RPAC_MT_DEVICE;
               shareable = 1'b1;
            end
            4'h2: begin
               mem_type           = `RPAC_MT_NORMAL;
               inner_cache_policy = `RPAC_POL_WT_NWA;
               outer_cache_policy = `RPAC_POL_WT_NWA;
            end
            4'h3: begin
               mem_type           = `RPAC_MT_NORMAL;
               inner_cache_policy = `RPAC_POL_WB_NWA;
               outer_cache_policy = `RPAC_POL_WB_NWA;
            end
            4'h4: mem_type = `RPAC_MT_NORMAL;
            4'h5: mem_type = `RPAC_MT_RESERVED;
            4'h6: begin
               mem_type     = `RPAC_MT_NORMAL;
               impl_defined = 1'b1;
            end
            4'h7: begin
               mem_type           = `RPAC_MT_NORMAL;
               inner_cache_policy = `RPAC_POL_WB_WRA;
               outer_cache_policy = `RPAC_POL_WB_WRA;
            end
            4'h8: begin
               mem_type  = `RPAC_MT_DEVICE;
               shareable = 1'b0;
            end
            default: mem_type = `RPAC_MT_RESERVED;
         endcase
      end
   end

endmodule

//--- testbench/rpac_top_props.sv
`timescale 1ns/1ns
`include "rpac_defs.vh"
module rpac_top_props (
   input wire        clock,
   input wire        rst_b,
   input wire        mpu_enable,
   input wire        handler_escalated,
   input wire        prog_we,
   input wire [1:0]  prog_word,
   input wire [31:0] prog_wdata,
   input wire [7:0]  region_select_reg,
   input wire        acc_valid,
   input wire [31:0] acc_addr,
   input wire        acc_priv,
   input wire        acc_fetch,
   input wire        acc_fault,
   input wire        attr_valid,
   input wire        attr_region_hit,
   input wire [2:0]  attr_region,
   input wire [1:0]  attr_mem_type,
   input wire        attr_shareable,
   input wire        memfault_exc,
   input wire [7:0]  memfault_status_bits,
   input wire [31:0] fault_addr
);
   wire [7:0] wd_lo = prog_wdata[7:0];
   wire [3:0] wd_nib = prog_wdata[3:0];
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   chk_exc_delay: assert property (memfault_exc == $past(acc_fault))
      else $error("exception pulse not one cycle after fault");
   chk_attr_valid: assert property (attr_valid == $past(acc_valid))
      else $error("attribute strobe not one cycle after access");
   chk_idle_quiet: assert property (
      !acc_valid || !mpu_enable |-> !acc_fault)
      else $error("fault without an active check");
   chk_user_miss: assert property (acc_valid && !acc_priv && mpu_enable
      && !handler_escalated |=> attr_region_hit || memfault_exc)
      else $error("unprivileged miss passed");
   chk_strong_share: assert property (attr_valid && attr_region_hit
      && attr_mem_type == `RPAC_MT_STRONG |-> attr_shareable)
      else $error("strongly ordered region not shareable");
   chk_data_status: assert property (
      acc_valid && acc_fault && !acc_fetch
      |=> memfault_status_bits[1] && memfault_status_bits[7]
      && fault_addr == $past(acc_addr))
      else $error("data fault not recorded");
   chk_fetch_status: assert property (
      acc_valid && acc_fault && acc_fetch |=> memfault_status_bits[0])
      else $error("fetch fault not recorded");
   chk_select_load: assert property (prog_we
      && prog_word == `RPAC_WORD_SELECT |=> region_select_reg == $past(wd_lo))
      else $error("select word not loaded");
   chk_base_select: assert property (prog_we && prog_wdata[4]
      && prog_word == `RPAC_WORD_BASE
      |=> region_select_reg[3:0] == $past(wd_nib))
      else $error("packed base did not load select");
   chk_attr_hold: assert property (!acc_valid |=> $stable(attr_region)
      && $stable(attr_mem_type))
      else $error("attributes changed without access");
   cover property (acc_valid && acc_fault && acc_fetch);
   cover property (attr_valid && attr_region_hit && attr_region == 3'h6);
   cover property (memfault_exc && !attr_region_hit);
endmodule

//--- testbench/rpac_core_model.sv
`timescale 1ns/1ns
`include "rpac_defs.vh"
// core side: region programming stores and load, store and fetch requests
module rpac_core_model (
   input  wire        clock,
   output reg         prog_we,
   output reg  [1:0]  prog_word,
   output reg  [31:0] prog_wdata,
   output reg         acc_valid,
   output reg  [31:0] acc_addr,
   output reg         acc_write,
   output reg         acc_priv,
   output reg         acc_fetch
);
   initial begin
      prog_we = 1'b0;
      prog_word = 2'h3;
      prog_wdata = 32'h0;
      acc_valid = 1'b0;
      acc_addr = 32'h0;
      acc_write = 1'b0;
      acc_priv = 1'b0;
      acc_fetch = 1'b0;
   end
   // released data and address lines show the inverse of their last value
   task idle;
      begin
         @(posedge clock);
         prog_we <= 1'b0;
         prog_wdata <= ~prog_wdata;
         acc_valid <= 1'b0;
         acc_addr <= ~acc_addr;
      end
   endtask
   task wr(input [1:0] w, input [31:0] d);
      begin
         @(posedge clock);
         prog_we <= 1'b1;
         prog_word <= w;
         prog_wdata <= d;
      end
   endtask
   // back to back words; odd regions use the packed base form
   task region(input [2:0] i, input [31:0] b, input [31:0] a);
      begin
         idle;
         if (i[0]) begin
            wr(`RPAC_WORD_BASE, {b[31:5], 2'b10, i});
         end else begin
            wr(`RPAC_WORD_SELECT, {29'h0, i});
            wr(`RPAC_WORD_BASE, {b[31:5], 5'h00});
         end
         wr(`RPAC_WORD_ATTR, a);
         idle;
         // settle time standing in for the barrier pair
         repeat (2) @(posedge clock);
      end
   endtask
   task access(input [31:0] a, input w, input p, input f);
      begin
         @(posedge clock);
         acc_valid <= 1'b1;
         acc_addr <= a;
         acc_write <= w;
         acc_priv <= p;
         acc_fetch <= f;
      end
   endtask
endmodule

//--- testbench/testbench.sv
`timescale 1ns/1ns
`include "rpac_defs.vh"
`define CHK(got, exp) begin \
   samples_checked = samples_checked + 1; \
   if ((got) !== (exp)) begin \
      failures = failures + 1; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
   end \
end
module testbench;
   typedef struct packed {
      logic fault; logic hit; logic [2:0] rgn; logic [1:0] mt; logic sh;
      logic [1:0] inn; logic [1:0] outr; logic impl;
   } rpac_note_t;
   reg         clock, rst_b, mpu_enable, privileged_background_enable;
   reg         hfnmi_enable, handler_escalated;
   reg  [1:0]  prog_rword;
   reg  [7:0]  memfault_clear;
   wire        prog_we, acc_valid, acc_write, acc_priv, acc_fetch, acc_fault;
   wire        attr_valid, attr_region_hit, attr_shareable;
   wire        attr_impl_defined, memfault_exc;
   wire [1:0]  prog_word, attr_mem_type;
   wire [1:0]  attr_inner_cache_policy, attr_outer_cache_policy;
   wire [2:0]  attr_region;
   wire [7:0]  region_select_reg, memfault_status_bits;
   wire [31:0] prog_wdata, acc_addr, prog_rdata, fault_addr;
   wire [3:0]  pol_got = {attr_inner_cache_policy, attr_outer_cache_policy};
   reg  [31:0] rd_exp;
   reg  [31:0] base_w [0:7];
   reg  [31:0] attr_w [0:7];
   rpac_note_t notes [$];
   rpac_note_t n;
   integer     failures, samples_checked, seed, k, r;
   rpac_core_model core (.clock, .prog_we, .prog_word, .prog_wdata,
      .acc_valid, .acc_addr, .acc_write, .acc_priv, .acc_fetch);
   rpac_top DUT (.clock, .rst_b, .mpu_enable, .privileged_background_enable,
      .hfnmi_enable, .handler_escalated, .prog_we, .prog_word, .prog_wdata,
      .prog_rword, .prog_rdata, .region_select_reg, .acc_valid, .acc_addr,
      .acc_write, .acc_priv, .acc_fetch, .acc_fault, .attr_valid,
      .attr_region_hit, .attr_region, .attr_mem_type, .attr_shareable,
      .attr_inner_cache_policy, .attr_outer_cache_policy, .attr_impl_defined,
      .memfault_exc, .memfault_clear, .memfault_status_bits, .fault_addr);
   function [31:0] mk(input [4:0] sz, input [7:0] msk, input [2:0] ext,
                      input [1:0] cb, input s, input [2:0] prm, input nx);
      mk = {3'h0, nx, 1'b0, prm, 2'h0, ext, s, cb,
            (sz < 5'h07) ? 8'h00 : msk, 2'h0, sz, 1'b1};
   endfunction
   function rpac_note_t predict(input [31:0] a, input w, input p, input f);
      rpac_note_t e;
      reg [31:0] at;
      integer j, sz;
      reg ok;
      begin
         e = '0;
         for (j = 0; j < 8; j = j + 1) begin
            at = attr_w[j];
            sz = at[5:1];
            if (at[0] && (a >> (sz + 1)) == (base_w[j] >> (sz + 1)) &&
                !(sz >= 7 && at[8 + ((a >> (sz - 2)) & 7)])) begin
               e.hit = 1'b1;
               e.rgn = j;
            end
         end
         at = attr_w[e.rgn];
         e.mt = `RPAC_MT_NORMAL;
         e.sh = at[18];
         casez ({at[21:19], at[17:16]})
            5'b000_00: {e.mt, e.sh} = {`RPAC_MT_STRONG, 1'b1};
            5'b000_01: {e.mt, e.sh} = {`RPAC_MT_DEVICE, 1'b1};
            5'b000_10: {e.inn, e.outr} = {2{`RPAC_POL_WT_NWA}};
            5'b000_11: {e.inn, e.outr} = {2{`RPAC_POL_WB_NWA}};
            5'b001_00: {e.inn, e.outr} = {2{`RPAC_POL_NC}};
            5'b001_10: e.impl = 1'b1;
            5'b001_11: {e.inn, e.outr} = {2{`RPAC_POL_WB_WRA}};
            5'b010_00: {e.mt, e.sh} = {`RPAC_MT_DEVICE, 1'b0};
            5'b1??_??: {e.outr, e.inn} = {at[20:19], at[17:16]};
            default: e.mt = `RPAC_MT_RESERVED;
         endcase
         case (at[26:24])
            3'h1: ok = p;
            3'h2: ok = p || !w;
            3'h3: ok = 1'b1;
            3'h5: ok = p && !w;
            3'h6, 3'h7: ok = !w;
            default: ok = 1'b0;
         endcase
         // no region is reported while protection is off
         if (!mpu_enable || (handler_escalated && !hfnmi_enable))
            {e.fault, e.hit} = 2'b00;
         else if (!e.hit)
            e.fault = !(p && privileged_background_enable);
         else
            e.fault = !ok || (f && at[28]);
         predict = e;
      end
   endfunction
   task setr(input [2:0] i, input [31:0] b, input [31:0] a);
      begin
         base_w[i] = b;
         attr_w[i] = a;
         core.region(i, b, a);
      end
   endtask
   task acc(input [31:0] a, input w, input p, input f);
      begin
         notes.push_back(predict(a, w, p, f));
         core.access(a, w, p, f);
      end
   endtask
   task settle;
      begin
         core.idle;
         @(negedge clock);
      end
   endtask
   task results;
      begin
         $display("checks %0d failures %0d", samples_checked, failures);
         if (failures == 0 && samples_checked > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   always @(negedge clock) begin
      if (attr_valid === 1'b1 && notes.size() == 0)
         `CHK(attr_valid, 1'b0)
      else if (attr_valid === 1'b1) begin
         n = notes.pop_front();
         `CHK(memfault_exc, n.fault)
         `CHK(attr_region_hit, n.hit)
         if (n.hit) begin
            `CHK(attr_region, n.rgn)
            `CHK(attr_mem_type, n.mt)
            `CHK(attr_impl_defined, n.impl)
            if (n.mt == `RPAC_MT_NORMAL)
               `CHK(pol_got, {n.inn, n.outr})
            if (n.mt != `RPAC_MT_RESERVED)
               `CHK(attr_shareable, n.sh)
         end
      end
   end
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial begin
      #400000;
      failures = failures + 1;
      results;
   end
   initial begin
      failures = 0;
      samples_checked = 0;
      seed = 53;
      rst_b = 1'b0;
      {mpu_enable, privileged_background_enable} = 2'h0;
      {hfnmi_enable, handler_escalated} = 2'h0;
      prog_rword = 2'h0;
      memfault_clear = 8'h00;
      for (k = 0; k < 8; k = k + 1) begin
         base_w[k] = 32'h0;
         attr_w[k] = 32'h0;
      end
      repeat (20) @(posedge clock);
      rst_b <= 1'b1;
      repeat (3) @(posedge clock);
      mpu_enable <= 1'b1;
      for (k = 0; k < 8; k = k + 1) begin
         setr(0, 32'h2000_0000, mk(5'h0b, 8'h00, 3'h0, 2'h2, 1'b0, k, 1'b0));
         for (r = 0; r < 4; r = r + 1)
            acc(32'h2000_0100, r[0], r[1], 1'b0);
      end
      $display("permission codes done");
      for (k = 0; k < 64; k = k + 1) begin
         setr(3, 32'h3000_0000,
              mk(5'h09, 8'h00, k[4:2], k[1:0], k[5], 3'h3, 1'b0));
         acc(32'h3000_0010, 1'b0, 1'b1, 1'b0);
      end
      $display("attribute encodings done");
      setr(0, 32'h2000_0000, mk(5'h0b, 8'h00, 3'h1, 2'h3, 1'b1, 3'h2, 1'b0));
      setr(6, 32'h2000_0000, mk(5'h09, 8'h81, 3'h0, 2'h2, 1'b0, 3'h1, 1'b0));
      setr(4, 32'h5000_0000, mk(5'h09, 8'h02, 3'h0, 2'h2, 1'b0, 3'h3, 1'b0));
      for (k = 0; k < 9; k = k + 1) begin
         acc(32'h2000_0004 + k * 128, 1'b0, k[0], 1'b0);
         acc(32'h5000_0004 + k * 128, 1'b1, 1'b1, 1'b0);
      end
      $display("subregions done");
      for (k = 0; k < 17; k = k + 1) begin
         core.idle;
         {mpu_enable, privileged_background_enable, hfnmi_enable,
          handler_escalated} <= (k == 16) ? 4'h8 : k[3:0];
         @(negedge clock);
         acc(32'h2000_0804, 1'b1, 1'b0, 1'b0);
         acc(32'h6000_0000, 1'b0, 1'b1, 1'b0);
         acc(32'h6000_0000, 1'b0, 1'b0, 1'b1);
      end
      $display("enable modes done");
      setr(2, 32'h4000_0000, mk(5'h04, 8'hff, 3'h0, 2'h2, 1'b0, 3'h6, 1'b1));
      setr(5, 32'h4000_0020, mk(5'h04, 8'h00, 3'h4, 2'h1, 1'b1, 3'h6, 1'b0));
      acc(32'h4000_0008, 1'b0, 1'b0, 1'b0);
      acc(32'h4000_0024, 1'b0, 1'b0, 1'b1);
      settle;
      for (k = 0; k < 4; k = k + 1) begin
         @(posedge clock);
         prog_rword <= k;
         @(posedge clock);
         @(negedge clock);
         rd_exp = (k == 1) ? {base_w[5][31:5], 5'h05} : 32'h0;
         rd_exp = (k == 0) ? 32'h5 : (k == 2) ? attr_w[5] : rd_exp;
         `CHK(prog_rdata, rd_exp)
      end
      @(posedge clock);
      memfault_clear <= 8'hff;
      @(posedge clock);
      memfault_clear <= 8'h00;
      @(negedge clock);
      `CHK(memfault_status_bits, 8'h00)
      acc(32'h4000_0004, 1'b0, 1'b1, 1'b1);
      settle;
      `CHK(memfault_status_bits, 8'h01)
      acc(32'h4000_0028, 1'b1, 1'b1, 1'b0);
      settle;
      `CHK(memfault_status_bits, 8'h83)
      `CHK(fault_addr, 32'h4000_0028)
      $display("fault status done");
      for (k = 0; k < 40; k = k + 1) begin
         r = $random(seed);
         acc(32'h2000_0800 + r[9:0], r[10], r[11], r[12] & ~r[10]);
      end
      settle;
      @(negedge clock);
      `CHK(notes.size(), 0)
      $display("random accesses done");
      results;
   end
endmodule
bind rpac_top rpac_top_props chk (.clock, .rst_b, .mpu_enable,
   .handler_escalated, .prog_we, .prog_word, .prog_wdata, .region_select_reg,
   .acc_valid, .acc_addr, .acc_priv, .acc_fetch, .acc_fault, .attr_valid,
   .attr_region_hit, .attr_region, .attr_mem_type, .attr_shareable,
   .memfault_exc, .memfault_status_bits, .fault_addr);
